/* inc/resume_consts.svh */
`ifndef RESUME_CONSTS_SVH
`define RESUME_CONSTS_SVH
// ==========================================
// Register indices (byte address is four times the index)
`define IDX_CAUSE 16'h28b0
`define IDX_SRC 16'h28b1
`define IDX_TCTL 16'h28b2
`define IDX_EN 16'h28b3
`define IDX_WDC 16'h28b4
`define IDX_CFG 16'h28b5
`define IDX_PWR 16'h28b6
`define IDX_TCNT 16'h2880
`define IDX_OPT 16'h2457
// ==========================================
// Reset-cause bits
`define B_CSTART 7
`define B_RSTPIN 6
`define B_RSTBIT 5
`define B_OVF 4
`define B_DRST 3
`define B_LOWB 2
// Resume source bits and enables
`define B_TMR 5
`define B_RX 4
`define B_PB 3
`define B_SEG4 2
`define B_SEG52 1
`define B_SEG55 0
// Control bits
`define B_SLEEP 7
`define B_HOLD 6
`define B_ARM 5
`define B_WDRST 7
`define B_OPTDIS 2
`define B_RSTCTL 0
`define B_CFG4 2
`define B_CFG52 3
`define B_CFG55 4
`define RST_BYTE 8'h00
// ==========================================
// Pin vector positions
`define P_PB 0
`define P_RX 1
`define P_SEG4 2
`define P_SEG52 3
`define P_SEG55 4
`define P_OPT 5
`define P_DBG 6
`define P_RST 7
`define P_DRST 8
`define P_COLD 9
`define P_LOWB 10
`define P_PWR 11
// ==========================================
// Timing
`define CLK_NS 10
`define SLOW_HZ 32768
`define SLOW_DIV (1000000000 / `CLK_NS / `SLOW_HZ)
`define DEB_NS 2000
`define DEB_CYC ((`DEB_NS + `CLK_NS - 1) / `CLK_NS)
`define SMP_MS 2
`define SMP_CYC (`SMP_MS * (1000000 / `CLK_NS))
`define LVL_MS 64
`define LVL_SMP (`LVL_MS / `SMP_MS)
`define WAKE_TICKS 3
`define WDOG_MS 1500
`define WDOG_CYC (`WDOG_MS * (1000000 / `CLK_NS))
`endif

/* inc/resume_pkg.sv */
// ==========================================
// Types of the resume sequencer
package resume_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } mode_t;

    typedef struct packed {
        mode_t mode;
        logic [11:0] s1;
        logic [11:0] s2;
        logic [11:0] prev;
        logic [2:0] pw1;
        logic [2:0] pw2;
        logic [11:0] slowDiv;
        logic [17:0] smpDiv;
        logic [1:0] wakeCnt;
        logic [4:0][7:0] lock;
        logic [2:0][5:0] lvl;
        logic [2:0] lvlOk;
        logic [27:0] wdog;
        logic [7:0] cause;
        logic [7:0] src;
        logic [7:0] tctl;
        logic [7:0] en;
        logic [7:0] cfg;
        logic [7:0] opt;
        logic [7:0] tcnt;
        logic [7:0] tmrVal;
        logic tmrRun;
        logic hold;
        logic wake;
        logic mains;
        logic sysRst;
        logic prdy;
        logic perr;
        logic [31:0] prdata;
    } state_t;
endpackage : resume_pkg

/* hw/resume_sequencer.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "resume_consts.svh"
module resume_sequencer
    import resume_pkg::*;
#(
    parameter int unsigned SMP_CYC = `SMP_CYC,
    parameter int unsigned WDOG_CYC = `WDOG_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Resume and reset pins
    input wire logic pushButtonPin,
    input wire logic serialRxPin,
    input wire logic segmentPin4,
    input wire logic segmentPin52,
    input wire logic segmentPin55,
    input wire logic opticalReceivePin,
    input wire logic debugEnablePin,
    input wire logic resetPin,
    input wire logic debugResetPin,
    input wire logic coldStartIn,
    input wire logic lowBatteryIn,
    input wire logic sysPowerOk,
    input wire logic [2:0] powerStatusIn,
    // Sequencer outputs
    output logic cpuHold,
    output logic resumeSignal,
    output logic mainsRunMode,
    output logic sysReset
);

    // ==========================================
    // Decode helper
    function automatic logic isReg(input logic [15:0] a, input logic [15:0] idx);
        isReg = (a == {idx[13:0], 2'b00});
    endfunction : isReg

    state_t st_r;
    state_t st_nxt;
    logic [11:0] pinsRaw;
    logic [11:0] rise;
    logic [11:0] chg;
    logic slowTick;
    logic smpTick;
    logic [4:0] edgeSrc;
    logic [4:0] edgeEv;
    logic [2:0] lvlIn;
    logic wr;
    logic [7:0] wdata;
    logic sleepReq;
    logic armWr;
    logic wdWr;
    logic rstBitWr;
    logic [5:0] pinMask;
    logic [5:0] srcEv;
    logic [5:0] setSrc;
    logic tmrEv;
    logic dbg;
    logic ovf;
    logic wakeFall;
    logic wakeDone;
    logic pwrRise;
    logic [7:0] causeEv;
    logic [7:0] clrOvf;

    assign pinsRaw = {sysPowerOk, lowBatteryIn, coldStartIn, debugResetPin, resetPin,
        debugEnablePin, opticalReceivePin, segmentPin55, segmentPin52, segmentPin4,
        serialRxPin, pushButtonPin};

    // ==========================================
    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        // Two-flop synchronisers, third stage for edges
        st_nxt.s1 = pinsRaw;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        st_nxt.pw1 = powerStatusIn;
        st_nxt.pw2 = st_r.pw1;
        rise = st_r.s2 & ~st_r.prev;
        chg = st_r.s2 ^ st_r.prev;
        dbg = st_r.s2[`P_DBG];
        pwrRise = rise[`P_PWR];

        // Slow crystal tick and 2 ms sample tick
        slowTick = (st_r.slowDiv == 12'(`SLOW_DIV - 1));
        st_nxt.slowDiv = slowTick ? 12'h000 : st_r.slowDiv + 12'h001;
        smpTick = (st_r.smpDiv == 18'(SMP_CYC - 1));
        st_nxt.smpDiv = smpTick ? 18'h00000 : st_r.smpDiv + 18'h00001;

        // First-transition detect with 2 us lockout
        edgeSrc = {rise[`P_DRST], rise[`P_RST], rise[`P_SEG4], chg[`P_OPT], chg[`P_RX]};
        edgeEv = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (st_r.lock[i] != 8'h00) begin
                st_nxt.lock[i] = st_r.lock[i] - 8'h01;
            end else if (edgeSrc[i]) begin
                edgeEv[i] = 1'b1;
                st_nxt.lock[i] = 8'(`DEB_CYC - 1);
            end
        end

        // Level filter: 32 consecutive high samples
        lvlIn = {st_r.s2[`P_SEG55], st_r.s2[`P_SEG52], st_r.s2[`P_PB]};
        for (int j = 0; j < 3; j++) begin
            if (smpTick) begin
                if (!lvlIn[j]) begin
                    st_nxt.lvl[j] = 6'h00;
                    st_nxt.lvlOk[j] = 1'b0;
                end else if (st_r.lvl[j] == 6'(`LVL_SMP - 1)) begin
                    st_nxt.lvlOk[j] = 1'b1;
                end else begin
                    st_nxt.lvl[j] = st_r.lvl[j] + 6'h01;
                end
            end
        end

        // Register writes
        wr = psel && penable && pwrite && st_r.prdy;
        wdata = pwdata[7:0];
        sleepReq = wr && isReg(paddr, `IDX_TCTL) && (wdata[`B_SLEEP] || wdata[`B_HOLD]);
        armWr = wr && isReg(paddr, `IDX_TCTL) && wdata[`B_ARM];
        wdWr = wr && isReg(paddr, `IDX_WDC) && wdata[`B_WDRST];
        rstBitWr = wr && isReg(paddr, `IDX_CFG) && wdata[`B_RSTCTL];
        if (wr && isReg(paddr, `IDX_EN)) begin
            st_nxt.en = {3'b000, wdata[4:0]};
        end
        if (wr && isReg(paddr, `IDX_CFG)) begin
            st_nxt.cfg = {3'b000, wdata[4:2], 2'b00};
        end
        if (wr && isReg(paddr, `IDX_OPT)) begin
            st_nxt.opt = {5'h00, wdata[`B_OPTDIS], 2'b00};
        end
        if (wr && isReg(paddr, `IDX_TCNT)) begin
            st_nxt.tcnt = wdata;
        end

        // Resume timer
        tmrEv = 1'b0;
        if (armWr) begin
            st_nxt.tmrVal = st_r.tcnt;
            st_nxt.tmrRun = 1'b1;
        end else if (st_r.tmrRun && st_r.mode == ST_SLEEP && smpTick) begin
            if (st_r.tmrVal == 8'h00) begin
                tmrEv = 1'b1;
                st_nxt.tmrRun = 1'b0;
            end else begin
                st_nxt.tmrVal = st_r.tmrVal - 8'h01;
            end
        end

        // Pin sources gated by enable, segment pins also by input configuration
        pinMask = {1'b1, st_r.en[`B_RX], st_r.en[`B_PB],
            st_r.en[`B_SEG4] & st_r.cfg[`B_CFG4],
            st_r.en[`B_SEG52] & st_r.cfg[`B_CFG52],
            st_r.en[`B_SEG55] & st_r.cfg[`B_CFG55]};
        srcEv = {tmrEv, edgeEv[0], st_r.lvlOk[0], edgeEv[2], st_r.lvlOk[1],
            st_r.opt[`B_OPTDIS] ? st_r.lvlOk[2] : edgeEv[1]} & pinMask;

        // Watchdog; the debug pin holds it off, restart writes and wake completion also restart it
        ovf = (st_r.wdog == 28'(WDOG_CYC - 1)) && !dbg;
        wakeFall = 1'b0;
        wakeDone = 1'b0;

        // Power mode sequencer
        st_nxt.mains = st_r.s2[`P_PWR];
        case (st_r.mode)
            ST_RUN: begin
                if (sleepReq && !st_r.s2[`P_PWR]) begin
                    st_nxt.mode = ST_SLEEP;
                    st_nxt.hold = 1'b1;
                    st_nxt.wake = 1'b0;
                    wakeFall = 1'b1;
                    st_nxt.tctl = {wdata[7:6], 6'h00};
                end
            end
            ST_SLEEP: begin
                if (pwrRise) begin
                    st_nxt.mode = ST_RUN;
                    st_nxt.hold = 1'b0;
                    st_nxt.wake = 1'b1;
                    wakeDone = 1'b1;
                end else if (|srcEv) begin
                    st_nxt.mode = ST_WAKE;
                    st_nxt.wake = 1'b1;
                    st_nxt.wakeCnt = 2'b00;
                end
            end
            ST_WAKE: begin
                if (pwrRise || (slowTick && st_r.wakeCnt == 2'(`WAKE_TICKS - 1))) begin
                    st_nxt.mode = ST_RUN;
                    st_nxt.hold = 1'b0;
                    wakeDone = 1'b1;
                end else if (slowTick) begin
                    st_nxt.wakeCnt = st_r.wakeCnt + 2'b01;
                end
            end
            default: begin
                st_nxt.mode = ST_RUN;
            end
        endcase
        if (wakeDone) begin
            st_nxt.tctl = `RST_BYTE;
        end

        // Watchdog restart sources
        st_nxt.wdog = (ovf || wdWr || dbg || wakeDone) ? 28'h0000000 :
            st_r.wdog + 28'h0000001;
        st_nxt.sysRst = ovf || rstBitWr;

        // Resume flags: set beats clear, writes never reach them
        setSrc = (st_r.mode == ST_SLEEP && !pwrRise) ? srcEv : 6'h00;
        setSrc[`B_PB] = srcEv[`B_PB];
        st_nxt.src = ((wakeFall ? `RST_BYTE : st_r.src) | {2'b00, setSrc})
            & {2'b00, pinMask};

        // Reset-cause flags
        causeEv = `RST_BYTE;
        causeEv[`B_OVF] = ovf;
        causeEv[`B_RSTBIT] = rstBitWr;
        causeEv[`B_RSTPIN] = edgeEv[3];
        causeEv[`B_DRST] = edgeEv[4] && dbg;
        causeEv[`B_CSTART] = rise[`P_COLD];
        causeEv[`B_LOWB] = rise[`P_LOWB];
        clrOvf = edgeEv[3] ? (8'h01 << `B_OVF) : 8'h00;
        st_nxt.cause = ((wakeFall ? `RST_BYTE : st_r.cause) & ~clrOvf) | causeEv;

        // APB read answer, ready in the access cycle
        st_nxt.prdy = psel && !penable;
        st_nxt.perr = 1'b0;
        st_nxt.prdata = 32'h00000000;
        if (psel && !penable) begin
            if (isReg(paddr, `IDX_CAUSE)) begin
                st_nxt.prdata = {24'h000000, st_r.cause};
            end else if (isReg(paddr, `IDX_SRC)) begin
                st_nxt.prdata = {24'h000000, st_r.src};
            end else if (isReg(paddr, `IDX_TCTL)) begin
                st_nxt.prdata = {24'h000000, st_r.tctl[7:6], st_r.tmrRun, 5'h00};
            end else if (isReg(paddr, `IDX_EN)) begin
                st_nxt.prdata = {24'h000000, st_r.en};
            end else if (isReg(paddr, `IDX_WDC)) begin
                st_nxt.prdata = 32'h00000000;
            end else if (isReg(paddr, `IDX_CFG)) begin
                st_nxt.prdata = {24'h000000, st_r.cfg};
            end else if (isReg(paddr, `IDX_PWR)) begin
                st_nxt.prdata = {29'h00000000, st_r.pw2};
            end else if (isReg(paddr, `IDX_TCNT)) begin
                st_nxt.prdata = {24'h000000, st_r.tcnt};
            end else if (isReg(paddr, `IDX_OPT)) begin
                st_nxt.prdata = {24'h000000, st_r.opt};
            end else begin
                st_nxt.perr = 1'b1;
            end
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.mode <= ST_RUN;
            st_r.wake <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata = st_r.prdata;
    assign pready = st_r.prdy;
    assign pslverr = st_r.perr;
    assign cpuHold = st_r.hold;
    assign resumeSignal = st_r.wake;
    assign mainsRunMode = st_r.mains;
    assign sysReset = st_r.sysRst;

    // ==========================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    property p_ovfFlag;
        ovf && !edgeEv[3] |=> st_r.cause[`B_OVF] && st_r.sysRst && st_r.wdog == 28'h0;
    endproperty
    a_ovfFlag: assert property (p_ovfFlag) else $error("overflow flag not set");

    property p_rstClr;
        edgeEv[3] && !ovf |=> !st_r.cause[`B_OVF] && st_r.cause[`B_RSTPIN];
    endproperty
    a_rstClr: assert property (p_rstClr) else $error("reset pin did not clear");

    property p_dbgInhibit;
        dbg [*2] |-> st_r.wdog == 28'h0 && (!st_r.sysRst || $past(rstBitWr));
    endproperty
    a_dbgInhibit: assert property (p_dbgInhibit) else $error("watchdog ran in debug");

    property p_wdRestart;
        wdWr |=> st_r.wdog == 28'h0 ##1 st_r.wdog <= 28'h1;
    endproperty
    a_wdRestart: assert property (p_wdRestart) else $error("restart ignored");

    property p_mains;
        st_r.mode == ST_SLEEP && pwrRise |=> st_r.mode == ST_RUN && !st_r.hold
            && st_r.src == $past(st_r.src);
    endproperty
    a_mains: assert property (p_mains) else $error("power return mishandled");

    property p_hold;
        st_r.mode != ST_RUN |-> st_r.hold;
    endproperty
    a_hold: assert property (p_hold) else $error("processor not held");

    property p_wakeRise;
        st_r.mode == ST_SLEEP && !pwrRise && |srcEv |=> st_r.wake && st_r.mode == ST_WAKE;
    endproperty
    a_wakeRise: assert property (p_wakeRise) else $error("resume not raised");

    property p_wakeCnt;
        st_r.mode == ST_WAKE |-> st_r.wakeCnt < 2'(`WAKE_TICKS);
    endproperty
    a_wakeCnt: assert property (p_wakeCnt) else $error("wake took too long");

    property p_lock;
        edgeEv[0] |=> !edgeEv[0] [*8];
    endproperty
    a_lock: assert property (p_lock) else $error("second transition taken");

    property p_pbRun;
        st_r.mode == ST_RUN && srcEv[`B_PB] |=> st_r.src[`B_PB];
    endproperty
    a_pbRun: assert property (p_pbRun) else $error("button flag missed");

    property p_maskClr;
        !pinMask[`B_RX] |=> !st_r.src[`B_RX];
    endproperty
    a_maskClr: assert property (p_maskClr) else $error("flag not held clear");

    property p_flagWr;
        wr && isReg(paddr, `IDX_SRC) && !wakeFall && setSrc == 6'h00
            && pinMask == 6'h3f |=> st_r.src == $past(st_r.src);
    endproperty
    a_flagWr: assert property (p_flagWr) else $error("flag byte written");

    c_sleep: cover property (st_r.mode == ST_RUN ##1 st_r.mode == ST_SLEEP);
    c_wake: cover property (st_r.mode == ST_WAKE ##1 st_r.mode == ST_RUN);
    c_ovf: cover property (ovf);
    c_power: cover property (st_r.mode == ST_SLEEP && pwrRise);

endmodule : resume_sequencer

/* test/resume_pins.sv */
`timescale 1ns/1ns
// ==========================================
// Far-side pins: push button, receive lines and segment inputs
module resume_pins
    import resume_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Pins, bit order button, serial, seg4, seg52, seg55, optical
    output logic [5:0] pin
);
    // Pulled down while nothing presses or sends
    initial begin
        pin = 6'h00;
    end

    // Move one pin to a level, chattering a while on edge pins
    task automatic drive(input int idx, input logic lvl, input int bounces);
        @(posedge ref_clk);
        pin[idx] <= lvl;
        for (int b = 0; b < 2 * bounces; b++) begin
            repeat (3) @(posedge ref_clk);
            pin[idx] <= ~pin[idx];
        end
        repeat (250) @(posedge ref_clk);
    endtask : drive
endmodule : resume_pins

/* test/resume_source_and_watchdog_flags_tb.sv */
`timescale 1ns/1ns
`include "resume_consts.svh"
// ==========================================
// Self-checking bench of the resume sequencer
module resume_source_and_watchdog_flags_tb
    import resume_pkg::*;
;
    logic ref_clk, rst_b, psel, penable, pwrite, debugEnablePin, sysPowerOk;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, cpuHold, resumeSignal, mainsRunMode, sysReset;
    logic [3:0] rstIn;
    logic [2:0] powerStatusIn;
    wire logic [5:0] pin;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int wdHits = 0;
    int enb[6] = '{3, 4, 2, 1, 0, 0};
    logic [7:0] cMask[4] = '{8'h50, 8'h80, 8'h04, 8'h08};
    logic [7:0] cExp[4] = '{8'h40, 8'h80, 8'h04, 8'h08};
    logic [15:0] regs[5] = '{`IDX_CAUSE, `IDX_SRC, `IDX_TCTL, `IDX_EN, `IDX_WDC};

    // ==========================================
    // Design and pin model
    resume_sequencer #(.SMP_CYC(20), .WDOG_CYC(200)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pushButtonPin(pin[0]),
        .serialRxPin(pin[1]), .segmentPin4(pin[2]), .segmentPin52(pin[3]),
        .segmentPin55(pin[4]), .opticalReceivePin(pin[5]),
        .debugEnablePin(debugEnablePin), .resetPin(rstIn[0]),
        .debugResetPin(rstIn[3]), .coldStartIn(rstIn[1]), .lowBatteryIn(rstIn[2]),
        .sysPowerOk(sysPowerOk), .powerStatusIn(powerStatusIn), .cpuHold(cpuHold),
        .resumeSignal(resumeSignal), .mainsRunMode(mainsRunMode), .sysReset(sysReset)
    );
    resume_pins pins (.ref_clk(ref_clk), .pin(pin));

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // System reset pulse count (overflow or reset bit) and run-time ceiling
    always @(posedge ref_clk) begin
        cycles++;
        if (sysReset === 1'b1) wdHits++;
        if (cycles == 98000) begin
            fail_count++;
            end_of_test();
        end
    end

    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, n < 50}, 32'h1, "apb answer");
    endtask : apb

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask : wr

    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp, input string msg);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 8'h00, d, e);
        chk(d, {24'h000000, exp}, msg);
    endtask : rdchk

    // Bounded wait: resume up (0) or processor let go (1)
    task automatic wait_on(input int which, output int n);
        n = 0;
        while (n < 12000 && ((which == 0) ? resumeSignal !== 1'b1 : cpuHold !== 1'b0)) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_on

    // Enter deep sleep or display hold at random
    task automatic sleep_enter(input logic [7:0] extra);
        logic [7:0] m;
        m = ($urandom_range(1, 0) == 1) ? 8'h80 : 8'h40;
        wr(`IDX_TCTL, m | extra);
        repeat (5) @(posedge ref_clk);
        chk({30'h0, resumeSignal, cpuHold}, 32'h1, "sleep holds processor");
    endtask : sleep_enter

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic e;
        int n, k, rot;
        logic [7:0] r;
        {psel, penable, pwrite, sysPowerOk, rst_b} = 5'h00;
        {paddr, pwdata, rstIn, powerStatusIn} = 55'h0;
        debugEnablePin = 1'b1;
        n = $urandom(32'hd415);
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        // Register reset values and access kinds
        foreach (regs[i]) rdchk(regs[i], 8'h00, "reset value");
        apb(1'b0, 16'h28bf, 8'h00, d, e);
        chk(d, 32'h0, "unmapped data");
        chk({31'h0, e}, 32'h1, "unmapped error");
        wr(`IDX_CAUSE, 8'hff);
        wr(`IDX_SRC, 8'hff);
        rdchk(`IDX_CAUSE, 8'h00, "cause write ignored");
        rdchk(`IDX_SRC, 8'h00, "flag write ignored");
        r = 8'($urandom_range(31, 0));
        wr(`IDX_EN, r);
        rdchk(`IDX_EN, r, "enable readback");
        // Watchdog restart, overflow and debug inhibit
        debugEnablePin <= 1'b0;
        k = wdHits;
        repeat (8) begin
            wr(`IDX_WDC, 8'h80);
            repeat (100) @(posedge ref_clk);
        end
        chk(wdHits - k, 0, "restart holds off overflow");
        repeat (300) @(posedge ref_clk);
        chk({31'h0, wdHits > k}, 32'h1, "overflow reset");
        debugEnablePin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        k = wdHits;
        repeat (600) @(posedge ref_clk);
        chk(wdHits - k, 0, "debug inhibits watchdog");
        rdchk(`IDX_CAUSE, 8'h10, "overflow flag kept");
        // Reset pin, cold start, low battery, debug reset
        for (int j = 0; j < 4; j++) begin
            @(posedge ref_clk);
            rstIn[j] <= 1'b1;
            repeat (300) @(posedge ref_clk);
            rstIn[j] <= 1'b0;
            apb(1'b0, `IDX_CAUSE, 8'h00, d, e);
            chk({24'h0, d[7:0] & cMask[j]}, {24'h0, cExp[j]}, "cause flag");
        end
        k = wdHits;
        wr(`IDX_CFG, 8'h1d);
        repeat (5) @(posedge ref_clk);
        chk(wdHits - k, 1, "reset bit pulse");
        apb(1'b0, `IDX_CAUSE, 8'h00, d, e);
        chk({31'h0, d[5]}, 32'h1, "reset bit flag");
        // Each pin source resumes and sets its flag; optical sets the seg55 flag (bit 0)
        rot = $urandom_range(5, 0);
        for (int i = 0; i < 6; i++) begin
            k = (i + rot) % 6;
            wr(`IDX_EN, 8'h00);
            wr(`IDX_OPT, (k == 5) ? 8'h00 : 8'h04);
            if ((k == 1 || k == 5) && $urandom_range(1, 0) == 1) pins.drive(k, 1'b1, 0);
            wr(`IDX_EN, 8'h01 << enb[k]);
            sleep_enter(8'h00);
            if (i == 0) rdchk(`IDX_CAUSE, 8'h00, "cause cleared on sleep");
            repeat ($urandom_range(300, 50)) @(posedge ref_clk);
            pins.drive(k, ~pin[k], (k == 0 || k == 3 || k == 4) ? 0 : $urandom_range(4, 1));
            wait_on(0, n);
            chk({31'h0, n < 12000}, 32'h1, "pin resume");
            wait_on(1, n);
            chk({31'h0, n <= 9163}, 32'h1, "processor release");
            rdchk(`IDX_SRC, 8'h01 << enb[k], "resume flag");
            pins.drive(k, 1'b0, 0);
        end
        // Timer resume with an unconfigured segment pin toggling
        wr(`IDX_CFG, 8'h00);
        wr(`IDX_EN, 8'h04);
        wr(`IDX_TCNT, 8'h28);
        wr(`IDX_TCTL, 8'h20);
        sleep_enter(8'h20);
        pins.drive(2, 1'b1, 0);
        wait_on(0, n);
        chk({31'h0, n > 400 && n < 12000}, 32'h1, "timer resume");
        wait_on(1, n);
        rdchk(`IDX_SRC, 8'h20, "timer flag only");
        pins.drive(2, 1'b0, 0);
        // Button press while running adds its flag
        wr(`IDX_EN, 8'h08);
        pins.drive(0, 1'b1, 0);
        repeat (500) @(posedge ref_clk);
        rdchk(`IDX_SRC, 8'h28, "button while running");
        pins.drive(0, 1'b0, 0);
        // Return of system power
        wr(`IDX_EN, 8'h00);
        powerStatusIn <= 3'h2;
        sleep_enter(8'h00);
        rdchk(`IDX_PWR, 8'h02, "battery status");
        sysPowerOk <= 1'b1;
        powerStatusIn <= 3'h0;
        wait_on(0, n);
        chk({31'h0, n < 20}, 32'h1, "power return resume");
        repeat (5) @(posedge ref_clk);
        chk({31'h0, mainsRunMode}, 32'h1, "mains run mode");
        rdchk(`IDX_SRC, 8'h00, "no resume flag");
        rdchk(`IDX_CAUSE, 8'h00, "no cause flag");
        rdchk(`IDX_PWR, 8'h00, "power stable");
        end_of_test();
    end
endmodule : resume_source_and_watchdog_flags_tb
